/* logic/oec_pkg.sv */
// package for the output enable control block: timing counts and carrier types
// assumes a single 200 MHz clock and pins already synchronised inside the block
// Function
// RULE1: auxiliary output follows inverted enable pin, or a software control bit.
// RULE2: inhibit high enables main outputs, low disables, only after enable met.
// RULE3: status bit 4 clear gives inhibit pin priority, set gives software control.
// RULE4: inhibit release acts only after 3 ms debounce counted after enable.
// RULE5: inhibit assertion acts only after 3 ms debounce; shorter lows ignored.
// RULE6: at least 3 ms lockout between consecutive inhibit driven enables.
// RULE7: target address derived from the two active low geographic address pins.
// RULE8: address captured once at start-up, held until next power cycle; the code relatches after every rst_n reset.
// RULE9: undriven enable pin reads high, auxiliary output stays off.
// RULE10: undriven inhibit pin reads high, main outputs not inhibited.
// RULE11: both edges of enable pin debounced for 3 ms before acting.
// RULE12: address pins must stay stable 5 ms at start-up before latching.
`default_nettype none
package oec_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 200;
	localparam int DEBOUNCE_MS = 3;
	localparam int ADDR_STABLE_MS = 5;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	localparam int ADDR_STABLE_CYC = ADDR_STABLE_MS * CYC_PER_MS;
	localparam int CNT_W = 21;
	// ****************************************
	// reset values and status layout
	// ****************************************
	localparam int PRIO_BIT = 4;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [1:0] ADDR_RST = 2'h0;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic aux_on;
		logic main_on;
	} oec_out_t;
	typedef struct packed {
		logic aux_en;
		logic main_en;
	} oec_sw_t;
endpackage
`default_nettype wire

/* logic/oec_top.sv */
// output enable control: debounce of enable and inhibit pins, lockout, address latch
// assumes pins are asynchronous; software bits come from logic on the same clock
// outputs are registered; the lockout and address checks sit at the end of the file
`timescale 1ns/1ps
`default_nettype none
module oec_top #(
	parameter int DEB_CYC = oec_pkg::DEBOUNCE_CYC,
	parameter int ADDR_CYC = oec_pkg::ADDR_STABLE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable_n,
	input wire logic inhibit_n,
	input wire logic geo_addr_bit0_n,
	input wire logic geo_addr_bit1_n,
	input wire logic [7:0] status_reg,
	input wire oec_pkg::oec_sw_t sw_ctrl,
	output oec_pkg::oec_out_t outs,
	output logic [1:0] geo_addr,
	output logic geo_addr_valid
);
	// ****************************************
	// synchronisers
	// ****************************************
	logic [3:0] sync1;
	logic [3:0] sync2;
	// two flops per pin; reset to high so idle pull-ups read released
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 4'hF;
			sync2 <= 4'hF;
		end else begin
			sync1 <= {geo_addr_bit1_n, geo_addr_bit0_n, inhibit_n, enable_n};
			sync2 <= sync1;
		end
	end
	// ****************************************
	// enable debounce
	// ****************************************
	logic en_lvl; // debounced pin level, 1 = high
	logic [oec_pkg::CNT_W-1:0] en_cnt;
	// true on the last cycle of a count that must run lim cycles
	function automatic logic cnt_done(input logic [oec_pkg::CNT_W-1:0] c, input int lim);
		cnt_done = (int'(c) >= lim - 1);
	endfunction
	// both edges must persist before the level is accepted [RULE11] [RULE9]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_lvl <= 1'b1;
			en_cnt <= '0;
		end else if (sync2[0] == en_lvl) begin
			en_cnt <= '0;
		end else if (cnt_done(en_cnt, DEB_CYC)) begin
			en_lvl <= sync2[0];
			en_cnt <= '0;
		end else begin
			en_cnt <= en_cnt + 1'b1;
		end
	end
	// aux request from the pin alone; software is merged at the output stage
	logic aux_pin_on;
	assign aux_pin_on = !en_lvl;
	// ****************************************
	// inhibit debounce
	// ****************************************
	logic inh_lvl;
	logic [oec_pkg::CNT_W-1:0] inh_cnt;
	// held low while the pin does not request the aux output, so a release always waits a full debounce
	// counted from the enable; short lows never reach inh_lvl [RULE4] [RULE5] [RULE10]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inh_lvl <= 1'b0;
			inh_cnt <= '0;
		end else if (!aux_pin_on) begin
			inh_lvl <= 1'b0;
			inh_cnt <= '0; // count restarts from enable
		end else if (sync2[1] == inh_lvl) begin
			inh_cnt <= '0;
		end else if (cnt_done(inh_cnt, DEB_CYC)) begin
			inh_lvl <= sync2[1];
			inh_cnt <= '0;
		end else begin
			inh_cnt <= inh_cnt + 1'b1;
		end
	end
	// ****************************************
	// main enable with lockout
	// ****************************************
	logic main_pin_on;
	logic [oec_pkg::CNT_W-1:0] lock_cnt;
	logic locked;
	logic inh_want;
	assign inh_want = aux_pin_on && inh_lvl; // [RULE2]
	// with equal debounce and lockout counts two enables are already two debounces apart,
	// so the lockout is a backstop that normal pin traffic never reaches
	// a re-enable waits out the lockout since the last enable [RULE6]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			main_pin_on <= 1'b0;
			locked <= 1'b0;
			lock_cnt <= '0;
		end else begin
			if (inh_want && !main_pin_on && !locked) begin
				main_pin_on <= 1'b1;
				locked <= 1'b1;
				lock_cnt <= '0;
			end else begin
				if (!inh_want)
					main_pin_on <= 1'b0;
				if (locked) begin
					if (cnt_done(lock_cnt, DEB_CYC))
						locked <= 1'b0;
					lock_cnt <= lock_cnt + 1'b1;
				end
			end
		end
	end
	// ****************************************
	// output selection
	// ****************************************
	// aux from pin or software; main from pin unless priority bit set [RULE1] [RULE3]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outs <= '0;
		end else begin
			outs.aux_on <= aux_pin_on || sw_ctrl.aux_en;
			outs.main_on <= status_reg[oec_pkg::PRIO_BIT] ? sw_ctrl.main_en : main_pin_on;
		end
	end
	// ****************************************
	// geographic address latch
	// ****************************************
	logic [1:0] ga_prev;
	logic [oec_pkg::CNT_W+1:0] ga_cnt;
	// latched once after a stable window, then frozen [RULE7] [RULE8] [RULE12]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ga_prev <= oec_pkg::ADDR_RST;
			ga_cnt <= '0;
			geo_addr <= oec_pkg::ADDR_RST;
			geo_addr_valid <= 1'b0;
		end else if (!geo_addr_valid) begin
			ga_prev <= sync2[3:2];
			if (sync2[3:2] != ga_prev) begin
				ga_cnt <= '0;
			end else if (int'(ga_cnt) >= ADDR_CYC - 1) begin
				geo_addr <= ~sync2[3:2];
				geo_addr_valid <= 1'b1;
			end else begin
				ga_cnt <= ga_cnt + 1'b1;
			end
		end
	end
	// ****************************************
	// checks
	// ****************************************
	AST_AUX_SW: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
		sw_ctrl.aux_en |=> outs.aux_on) else $error("aux not on under software");
	AST_AUX_PIN: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
		!sw_ctrl.aux_en |=> outs.aux_on == $past(aux_pin_on)) else $error("aux not following pin");
	AST_MAIN_NEEDS_EN: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
		main_pin_on |-> $past(aux_pin_on)) else $error("main on without enable");
	AST_MAIN_OFF: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
		!inh_want |=> !main_pin_on) else $error("main stayed on while inhibited");
	AST_PRIO: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
		!status_reg[oec_pkg::PRIO_BIT] |=> outs.main_on == $past(main_pin_on)) else $error("pin priority broken");
	AST_PRIO_SW: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
		status_reg[oec_pkg::PRIO_BIT] |=> outs.main_on == $past(sw_ctrl.main_en))
		else $error("software priority broken");
	AST_EN_STABLE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
		$changed(en_lvl) |-> $past(sync2[0]) == en_lvl)
		else $error("enable level changed without pin");
	AST_EN_CNT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
		$changed(en_lvl) |-> int'($past(en_cnt)) == DEB_CYC - 1) else $error("enable debounce short");
	// ****************************************
	// checks: inhibit and lockout
	// ****************************************
	// first cycle in which the debounced pin asks for the aux output
	sequence s_en_rise;
		!aux_pin_on ##1 aux_pin_on;
	endsequence
	AST_INH_ARM: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
		s_en_rise |-> !inh_lvl && !main_pin_on) else $error("release not rearmed by enable");
	AST_INH_STABLE: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		$changed(inh_lvl) && $past(aux_pin_on) |-> $past(sync2[1]) == inh_lvl)
		else $error("inhibit level changed without pin");
	AST_INH_CNT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
		$changed(inh_lvl) && $past(aux_pin_on) |-> int'($past(inh_cnt)) == DEB_CYC - 1)
		else $error("inhibit debounce short");
	AST_LOCK: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
		$rose(main_pin_on) |-> locked && !$past(locked)) else $error("enable without lockout");
	AST_LOCK_LEN: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
		$fell(locked) |-> int'($past(lock_cnt)) == DEB_CYC - 1) else $error("lockout length wrong");
	// cycles since the last rise of the pin driven main enable, for the lockout check only
	logic main_prev;
	logic seen_rise;
	logic [oec_pkg::CNT_W-1:0] since_rise;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			main_prev <= 1'b0;
			seen_rise <= 1'b0;
			since_rise <= '0;
		end else begin
			main_prev <= main_pin_on;
			if (main_pin_on && !main_prev) begin
				seen_rise <= 1'b1;
				since_rise <= '0;
			end else if (!(&since_rise)) begin
				since_rise <= since_rise + 1'b1; // saturates
			end
		end
	end
	AST_LOCK_GAP: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
		main_pin_on && !main_prev && seen_rise |-> int'(since_rise) >= DEB_CYC - 1)
		else $error("main re-enabled inside lockout");
	// ****************************************
	// checks: geographic address
	// ****************************************
	// the cycle in which the address is first shown as valid
	sequence s_addr_take;
		!geo_addr_valid ##1 geo_addr_valid;
	endsequence
	AST_ADDR_VAL: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
		s_addr_take |-> geo_addr == ~$past(sync2[3:2])) else $error("address not from pins");
	AST_ADDR_WAIT: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
		s_addr_take |-> int'($past(ga_cnt)) >= ADDR_CYC - 1) else $error("address taken too early");
	AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
		geo_addr_valid |=> geo_addr_valid && $stable(geo_addr)) else $error("address changed");
endmodule
`default_nettype wire

/* tb/oec_ctrl_model.sv */
// controller model: drives the enable, inhibit and address pins
// assumes the bench sets levels; a released pin reads high
`timescale 1ns/1ps
`default_nettype none
module oec_ctrl_model (
	input wire logic drv_en,
	input wire logic lvl_en,
	input wire logic drv_inh,
	input wire logic lvl_inh,
	input wire logic [1:0] ga,
	output logic enable_n,
	output logic inhibit_n,
	output logic [1:0] ga_n
);
	// released pins go high through the pull-up
	assign enable_n = drv_en ? lvl_en : 1'b1;
	assign inhibit_n = drv_inh ? lvl_inh : 1'b1;
	assign ga_n = ~ga;
endmodule
`default_nettype wire

/* tb/tb_oec_top.sv */
// bench for the output enable control block
// assumes shortened counts: debounce 8, address 10
`timescale 1ns/1ps
`default_nettype none
module tb_oec_top;
	localparam int D = 8;
	logic clk = 0, rst_n = 0, de = 0, le = 1, di = 0, li = 1, gv;
	logic [1:0] ga = 2'h0, ega, gaddr;
	logic [7:0] st = 8'h00;
	logic [31:0] rnd = 32'h000171B3;
	oec_pkg::oec_sw_t sw = '0;
	oec_pkg::oec_out_t outs;
	wire logic en_n, in_n;
	wire logic [1:0] ga_n;
	int err_total = 0, samples_checked = 0, cyc = 0;
	int pe = 0, ih = 1, pr = 0, sa = 0, sm = 0, ea, em;
	oec_ctrl_model u_ctl (.drv_en(de), .lvl_en(le), .drv_inh(di), .lvl_inh(li), .ga(ga),
		.enable_n(en_n), .inhibit_n(in_n), .ga_n(ga_n));
	oec_top #(.DEB_CYC(D), .ADDR_CYC(10)) u_dut (.clk(clk), .rst_n(rst_n), .enable_n(en_n),
		.inhibit_n(in_n), .geo_addr_bit0_n(ga_n[0]), .geo_addr_bit1_n(ga_n[1]),
		.status_reg(st), .sw_ctrl(sw), .outs(outs), .geo_addr(gaddr), .geo_addr_valid(gv));
	// ****************************************
	// clock, timeout and helpers
	// ****************************************
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			conclude();
		end
	end
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp(logic [1:0] got, logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(negedge clk);
	endtask
	// integer model of the outputs after settling
	task automatic chk();
		wt(5 * D);
		ea = (pe | sa) != 0;
		em = pr ? sm : (pe & ih);
		cmp(outs, {ea[0], em[0]});
	endtask
	task automatic conclude();
		if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		ga = rnd[1:0];
		ega = rnd[1:0];
		wt(6);
		rst_n = 1;
		wt(20);
		cmp(gaddr, ega);
		cmp({1'b0, gv}, 2'h1);
		chk();
		de = 1; le = 0; pe = 1;
		chk();
		di = 1; li = 0; wt(3); li = 1;
		chk();
		li = 0; ih = 0;
		chk();
		li = 1; ih = 1;
		chk();
		ga = ~ga;
		wt(20);
		cmp(gaddr, ega);
		rnd = lfsr(rnd);
		st = 8'h10; pr = 1; li = 0; sm = rnd[0]; sw.main_en = rnd[0];
		chk();
		sm = !rnd[0]; sw.main_en = !rnd[0];
		chk();
		st = 8'h00; pr = 0; li = 1;
		chk();
		le = 1; wt(3); le = 0;
		chk();
		le = 1; pe = 0;
		chk();
		sw.aux_en = 1; sa = 1;
		chk();
		rst_n = 0;
		wt(2);
		rst_n = 1;
		ega = ~ega;
		wt(20);
		cmp(gaddr, ega);
		chk();
		conclude();
	end
endmodule
`default_nettype wire
